/* File: sbcsm_pkg.sv */
package sbcsm_pkg;

	// Frame layout, most significant bit first on the serial line.
	localparam int SBCSM_FRAME_BITS = 16;
	localparam int SBCSM_HEADER_BITS = 4;
	localparam int SBCSM_DATA_BITS = 12;
	localparam logic [4:0] SBCSM_FRAME_LAST = 5'h10;
	localparam logic [4:0] SBCSM_HEADER_LAST = 5'h04;

	// Register select codes carried in frame bits 15 and 14.
	localparam logic [1:0] SBCSM_ADDR_SPECIAL = 2'h1;
	localparam logic [1:0] SBCSM_ADDR_USER_A = 2'h2;
	localparam logic [1:0] SBCSM_ADDR_USER_B = 2'h3;

	// Field positions inside the 12-bit data part of a frame.
	localparam int SBCSM_ID_FLAG_POS = 11;
	localparam int SBCSM_SDM_POS = 9;
	localparam int SBCSM_EMU_POS = 8;
	localparam int SBCSM_PRESCALE_LSB = 5;
	localparam int SBCSM_LEVEL_LSB = 3;

	// Values after reset.
	localparam logic [11:0] SBCSM_SPECIAL_RST = 12'h000;
	localparam logic [11:0] SBCSM_USER_B_RST = 12'h000;
	localparam logic [2:0] SBCSM_ACC_RST = 3'h0;

	// Watchdog prescale factors expressed in half base periods.
	localparam logic [2:0] SBCSM_HALF_PER_BASE = 3'h2;
	localparam logic [2:0] SBCSM_PRE_X1 = 3'h2;
	localparam logic [2:0] SBCSM_PRE_X1_5 = 3'h3;
	localparam logic [2:0] SBCSM_PRE_X2_5 = 3'h5;
	localparam logic [2:0] SBCSM_PRE_X3_5 = 3'h7;

	// Main supply reset thresholds in percent of nominal.
	localparam logic [7:0] SBCSM_LEVEL_90 = 8'h5a;
	localparam logic [7:0] SBCSM_LEVEL_80 = 8'h50;
	localparam logic [7:0] SBCSM_LEVEL_70 = 8'h46;

	typedef enum logic [1:0] {
		SBCSM_MODE_NONE = 2'b00,
		SBCSM_MODE_POWER_ON = 2'b01,
		SBCSM_MODE_STARTUP = 2'b10,
		SBCSM_MODE_RESTART = 2'b11
	} sbcsm_mode_t;

	typedef struct packed {
		logic [1:0] register_select_bits;
		logic readback_select;
		logic write_inhibit_flag;
		logic [11:0] data;
	} sbcsm_frame_t;

	typedef struct packed {
		logic [1:0] rsv_hi;
		logic sw_dev_mode_init;
		logic fault_pin_emulation;
		logic rsv_mid;
		logic [1:0] watchdog_prescale;
		logic [1:0] supply_reset_level;
		logic [2:0] rsv_lo;
	} sbcsm_special_t;

	typedef struct packed {
		logic [11:0] int_enable;
		logic [11:0] sys_config;
		logic [11:0] phy_control;
	} sbcsm_ext_rb_t;

endpackage

/* File: sbcsm_shift.sv */
module sbcsm_shift
	import sbcsm_pkg::*;
(
	// Clock and reset.
	input wire logic clk_in,
	input wire logic arst_n_in,
	// Serial pins.
	input wire logic sck_in,
	input wire logic cs_n_in,
	input wire logic sdi_in,
	output logic sdo_out,
	// Towards the register bank.
	output logic [3:0] header_out,
	input wire logic [11:0] load_data_in,
	output sbcsm_frame_t frame_out,
	output logic frame_done_out
);

	typedef enum logic [1:0] {
		SBCSM_SH_IDLE = 2'b00,
		SBCSM_SH_SHIFT = 2'b01,
		SBCSM_SH_FULL = 2'b10,
		SBCSM_SH_BAD = 2'b11
	} sbcsm_sh_state_t;

	sbcsm_sh_state_t state, next_state;
	logic [4:0] count, next_count;
	logic [15:0] rx, next_rx;
	logic [11:0] tx, next_tx;
	logic sck_prev, next_sck_prev;
	logic sdo, next_sdo;
	logic done, next_done;
	logic rise, fall;

	assign rise = sck_in & ~sck_prev;
	assign fall = ~sck_in & sck_prev;
	assign header_out = rx[3:0];
	assign frame_out = rx;
	assign sdo_out = sdo;
	assign frame_done_out = done;

	// Sampling on the rising and shifting on the falling clock edge; the first
	// four bits go out as zero because the readback is not chosen until then.
	always_comb begin
		next_state = state;
		next_count = count;
		next_rx = rx;
		next_tx = tx;
		next_sck_prev = sck_in;
		next_sdo = sdo;
		next_done = 1'b0;
		if (cs_n_in) begin
			next_done = (state == SBCSM_SH_FULL);
			next_state = SBCSM_SH_IDLE;
			next_count = 5'h00;
			next_sdo = 1'b0;
		end else begin
			case (state)
				SBCSM_SH_IDLE: begin
					next_state = SBCSM_SH_SHIFT;
					next_tx = 12'h000;
				end
				SBCSM_SH_SHIFT: begin
					if (rise) begin
						next_rx = {rx[14:0], sdi_in};
						next_count = count + 5'h01;
						if (count + 5'h01 == SBCSM_FRAME_LAST) begin
							next_state = SBCSM_SH_FULL;
						end
					end
					if (fall && count == SBCSM_HEADER_LAST) begin
						next_sdo = load_data_in[11];
						next_tx = {load_data_in[10:0], 1'b0};
					end else if (fall && count > SBCSM_HEADER_LAST) begin
						next_sdo = tx[11];
						next_tx = {tx[10:0], 1'b0};
					end
				end
				SBCSM_SH_FULL: begin
					if (rise) begin
						next_state = SBCSM_SH_BAD;
					end
				end
				SBCSM_SH_BAD: begin
					next_state = SBCSM_SH_BAD;
				end
				default: begin
					next_state = SBCSM_SH_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			state <= SBCSM_SH_IDLE;
			count <= 5'h00;
			rx <= 16'h0000;
			tx <= 12'h000;
			sck_prev <= 1'b0;
			sdo <= 1'b0;
			done <= 1'b0;
		end else begin
			state <= next_state;
			count <= next_count;
			rx <= next_rx;
			tx <= next_tx;
			sck_prev <= next_sck_prev;
			sdo <= next_sdo;
			done <= next_done;
		end
	end

endmodule

/* File: sbcsm_regs.sv */
// Notes on behaviour
// - Address code 01 selects special mode register.
// - Select bit picks interrupt-enable or special readback.
// - Inhibit flag set: read only, no store.
// - Bit 9 starts software development mode.
// - Emulation on: enable high only without bus fault.
// - Emulation off: enable keeps ordinary function.
// - Prescale codes scale watchdog by 1/1.5/2.5/3.5.
// - Level codes choose 90, 80 or 70 percent.
// - Two 12-bit user words with readback.
// - Power-up loads identity code, clears replaced flag.
// - Any write to word A sets replaced flag.
// - Address 10 reads word A or system configuration.
// - User frames store only when not inhibited.
// - Address 11 reads word B or physical control.
// - Mode entry forces predefined register values.
module sbcsm_regs
	import sbcsm_pkg::*;
#(
	// Arbitrary identity value; replace with the real chip type and version.
	parameter logic [10:0] ID_CODE = 11'h2a5
)
(
	// Clock and reset.
	input wire logic clk_in,
	input wire logic arst_n_in,
	// Serial pins from the microcontroller.
	input wire logic sck_in,
	input wire logic cs_n_in,
	input wire logic sdi_in,
	output logic sdo_out,
	// Readback words owned by neighbouring register blocks.
	input sbcsm_ext_rb_t ext_readback_in,
	// Mode entry from the system controller.
	input wire logic mode_event_in,
	input sbcsm_mode_t mode_kind_in,
	// Enable pin sources.
	input wire logic en_function_in,
	input wire logic [3:0] bus_failure_code_in,
	output logic en_pin_out,
	// Watchdog timebase.
	input wire logic wd_base_tick_in,
	output logic wd_tick_out,
	// Main supply monitor, sample in percent of nominal.
	input wire logic [7:0] supply_pct_in,
	output logic supply_reset_out,
	output logic [7:0] supply_level_pct_out,
	// Configuration seen by other blocks.
	output logic sw_dev_mode_init_out,
	output logic [1:0] watchdog_prescale_out,
	output logic [1:0] supply_reset_level_out,
	output logic id_replaced_flag_out,
	output logic [11:0] user_bits_b_out
);

	sbcsm_frame_t frame;
	logic frame_done;
	logic [3:0] header;
	logic [11:0] readback;

	sbcsm_special_t special, next_special;
	logic [11:0] user_a, next_user_a;
	logic [11:0] user_b, next_user_b;

	logic [2:0] wd_acc, next_wd_acc;
	logic [2:0] wd_step;
	logic [3:0] wd_sum;
	logic wd_tick, next_wd_tick;

	logic [7:0] level_pct;
	logic en_pin, next_en_pin;
	logic supply_reset, next_supply_reset;
	logic [7:0] level_q, next_level_q;

	sbcsm_shift u_shift (
		.clk_in(clk_in),
		.arst_n_in(arst_n_in),
		.sck_in(sck_in),
		.cs_n_in(cs_n_in),
		.sdi_in(sdi_in),
		.sdo_out(sdo_out),
		.header_out(header),
		.load_data_in(readback),
		.frame_out(frame),
		.frame_done_out(frame_done)
	);

	// Readback choice from the first four bits, ready before the fifth
	// bit is shifted out.
	always_comb begin
		readback = 12'h000;
		case (header[3:2])
			SBCSM_ADDR_SPECIAL: begin
				readback = header[1] ? special : ext_readback_in.int_enable;
			end
			SBCSM_ADDR_USER_A: begin
				readback = header[1] ? user_a : ext_readback_in.sys_config;
			end
			SBCSM_ADDR_USER_B: begin
				readback = header[1] ? user_b : ext_readback_in.phy_control;
			end
			default: begin
				readback = 12'h000;
			end
		endcase
	end

	// Register stores. Only complete 16-bit frames commit; a mode entry in
	// the same cycle as a commit wins because it reflects a system reset.
	always_comb begin
		next_special = special;
		next_user_a = user_a;
		next_user_b = user_b;
		if (mode_event_in && mode_kind_in != SBCSM_MODE_NONE) begin
			next_special = SBCSM_SPECIAL_RST;
			if (mode_kind_in == SBCSM_MODE_POWER_ON) begin
				next_user_a = {1'b0, ID_CODE};
				next_user_b = SBCSM_USER_B_RST;
			end
		end else if (frame_done && !frame.write_inhibit_flag) begin
			case (frame.register_select_bits)
				SBCSM_ADDR_SPECIAL: begin
					next_special = frame.data;
					// Reserved bits are kept at zero so they read back as zero.
					next_special.rsv_hi = 2'b00;
					next_special.rsv_mid = 1'b0;
					next_special.rsv_lo = 3'b000;
				end
				SBCSM_ADDR_USER_A: begin
					next_user_a = frame.data;
					next_user_a[SBCSM_ID_FLAG_POS] = 1'b1;
				end
				SBCSM_ADDR_USER_B: begin
					next_user_b = frame.data;
				end
				default: begin
					next_user_b = user_b;
				end
			endcase
		end
	end

	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			special <= SBCSM_SPECIAL_RST;
			user_a <= {1'b0, ID_CODE};
			user_b <= SBCSM_USER_B_RST;
		end else begin
			special <= next_special;
			user_a <= next_user_a;
			user_b <= next_user_b;
		end
	end

	// Watchdog prescaler as a fractional accumulator in half base periods,
	// so the half-step factors need no faster clock. The scaled tick keeps
	// the right average rate; single intervals jitter by half a base period.
	always_comb begin
		case (special.watchdog_prescale)
			2'b00: wd_step = SBCSM_PRE_X1;
			2'b01: wd_step = SBCSM_PRE_X1_5;
			2'b10: wd_step = SBCSM_PRE_X2_5;
			2'b11: wd_step = SBCSM_PRE_X3_5;
			default: wd_step = SBCSM_PRE_X1;
		endcase
		wd_sum = {1'b0, wd_acc} + {1'b0, SBCSM_HALF_PER_BASE};
		next_wd_acc = wd_acc;
		next_wd_tick = 1'b0;
		if (wd_base_tick_in) begin
			if (wd_sum >= {1'b0, wd_step}) begin
				next_wd_acc = 3'(wd_sum - {1'b0, wd_step});
				next_wd_tick = 1'b1;
			end else begin
				next_wd_acc = wd_sum[2:0];
			end
		end
	end

	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			wd_acc <= SBCSM_ACC_RST;
			wd_tick <= 1'b0;
		end else begin
			wd_acc <= next_wd_acc;
			wd_tick <= next_wd_tick;
		end
	end

	// Supply threshold, enable pin and exported configuration.
	always_comb begin
		case (special.supply_reset_level)
			2'b01: level_pct = SBCSM_LEVEL_80;
			2'b10: level_pct = SBCSM_LEVEL_70;
			default: level_pct = SBCSM_LEVEL_90;
		endcase
		next_level_q = level_pct;
		next_supply_reset = (supply_pct_in < level_pct);
		if (special.fault_pin_emulation) begin
			next_en_pin = (bus_failure_code_in == 4'h0);
		end else begin
			next_en_pin = en_function_in;
		end
	end

	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			en_pin <= 1'b0;
			supply_reset <= 1'b0;
			level_q <= SBCSM_LEVEL_90;
		end else begin
			en_pin <= next_en_pin;
			supply_reset <= next_supply_reset;
			level_q <= next_level_q;
		end
	end

	assign en_pin_out = en_pin;
	assign supply_reset_out = supply_reset;
	assign supply_level_pct_out = level_q;
	assign wd_tick_out = wd_tick;
	assign sw_dev_mode_init_out = special.sw_dev_mode_init;
	assign watchdog_prescale_out = special.watchdog_prescale;
	assign supply_reset_level_out = special.supply_reset_level;
	assign id_replaced_flag_out = user_a[SBCSM_ID_FLAG_POS];
	assign user_bits_b_out = user_b;

endmodule

/* File: sbcsm_mcu.sv */
module sbcsm_mcu
	import sbcsm_pkg::*;
(
	// Clock and frame request.
	input wire logic clk_in,
	input wire logic go_in,
	input wire logic [4:0] nbits_in,
	input wire logic [15:0] word_in,
	// Serial pins.
	input wire logic sdo_in,
	output logic sck_out,
	output logic cs_n_out,
	output logic sdi_out,
	// Frame status.
	output logic busy_out,
	output logic done_out,
	output logic [15:0] rx_out
);
	timeunit 1ns;
	timeprecision 1ps;

	task automatic step(input int n);
		repeat (n) begin
			@(posedge clk_in);
			#1;
		end
	endtask

	initial begin
		sck_out = 1'b0;
		cs_n_out = 1'b1;
		sdi_out = 1'b0;
		busy_out = 1'b0;
		done_out = 1'b0;
		rx_out = 16'h0000;
		forever begin
			step(1);
			done_out = 1'b0;
			// Outside a frame the data line carries no stale bit.
			sdi_out = ~sdi_out;
			if (go_in) begin
				busy_out = 1'b1;
				cs_n_out = 1'b0;
				for (int i = 0; i < nbits_in; i++) begin
					sdi_out = word_in[4'(15 - i)];
					step(3);
					rx_out = {rx_out[14:0], sdo_in};
					sck_out = 1'b1;
					step(2);
					sck_out = 1'b0;
				end
				step(1);
				cs_n_out = 1'b1;
				step(4);
				busy_out = 1'b0;
				done_out = 1'b1;
			end
		end
	end
endmodule

/* File: sbcsm_regs_sva.sv */
module sbcsm_regs_sva
	import sbcsm_pkg::*;
(
	// Clock and reset.
	input wire logic clk_in,
	input wire logic arst_n_in,
	// Inputs.
	input wire logic cs_n_in,
	input wire logic mode_event_in,
	input sbcsm_mode_t mode_kind_in,
	input wire logic wd_base_tick_in,
	// Outputs.
	input wire logic sdo_out,
	input wire logic wd_tick_out,
	input wire logic [7:0] supply_level_pct_out,
	input wire logic sw_dev_mode_init_out,
	input wire logic [1:0] watchdog_prescale_out,
	input wire logic [1:0] supply_reset_level_out,
	input wire logic id_replaced_flag_out,
	input wire logic [11:0] user_bits_b_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!arst_n_in);
	wire [4:0] cfg = {sw_dev_mode_init_out, watchdog_prescale_out, supply_reset_level_out};

	level_map_a: assert property ($stable(supply_reset_level_out) |->
		supply_level_pct_out == (supply_reset_level_out == 2'h1 ? 8'h50 :
		supply_reset_level_out == 2'h2 ? 8'h46 : 8'h5a)) else $error("level map");
	wd_latency_a: assert property (wd_tick_out |-> $past(wd_base_tick_in))
		else $error("wd latency");
	wd_unit_a: assert property (watchdog_prescale_out == 2'h0 &&
		$stable(watchdog_prescale_out) && $past(wd_base_tick_in) |-> wd_tick_out)
		else $error("wd unit");
	idle_low_a: assert property (cs_n_in && $past(cs_n_in) && $past(cs_n_in, 2) |->
		!sdo_out) else $error("sdo idle");
	header_zero_a: assert property ($fell(cs_n_in) |-> !sdo_out [*8])
		else $error("header bits");
	flag_set_a: assert property ($rose(id_replaced_flag_out) |->
		cs_n_in && $past(cs_n_in)) else $error("flag set");
	power_on_a: assert property (mode_event_in && mode_kind_in == SBCSM_MODE_POWER_ON |=>
		cfg == 5'h00 && !id_replaced_flag_out && user_bits_b_out == 12'h000)
		else $error("power on");
	mode_clear_a: assert property (mode_event_in && mode_kind_in inside
		{SBCSM_MODE_STARTUP, SBCSM_MODE_RESTART} |=> cfg == 5'h00 &&
		$stable(user_bits_b_out)) else $error("mode clear");
endmodule

bind sbcsm_regs sbcsm_regs_sva sbcsm_regs_sva_i (.clk_in, .arst_n_in, .cs_n_in,
	.mode_event_in, .mode_kind_in, .wd_base_tick_in, .sdo_out, .wd_tick_out,
	.supply_level_pct_out, .sw_dev_mode_init_out, .watchdog_prescale_out,
	.supply_reset_level_out, .id_replaced_flag_out, .user_bits_b_out);

/* File: sbcsm_regs_tb.sv */
module sbcsm_regs_tb
	import sbcsm_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin fail_count++; \
	$display("mismatch t=%0t got=%h exp=%h", $time, a, b); end end
	// Arbitrary identity value.
	localparam logic [10:0] ID = 11'h15a;
	logic clk_in = 1'b0, arst_n_in = 1'b0, sck_in, cs_n_in, sdi_in, sdo_out, busy, done;
	logic go = 1'b0, mode_event_in = 1'b0, en_function_in = 1'b0, wd_base_tick_in = 1'b0;
	logic en_pin_out, wd_tick_out, supply_reset_out, sw_dev_mode_init_out, id_replaced_flag_out;
	logic [1:0] watchdog_prescale_out, supply_reset_level_out;
	logic [3:0] bus_failure_code_in = 4'h0;
	logic [4:0] nb = 5'h10;
	logic [7:0] supply_pct_in = 8'h64, supply_level_pct_out;
	logic [11:0] user_bits_b_out, d, r;
	logic [15:0] tx = 16'h0000, rx, e, sp = 16'h0000;
	logic [15:0] q[$];
	sbcsm_mode_t mode_kind_in = SBCSM_MODE_NONE;
	sbcsm_ext_rb_t ext_readback_in = {12'h5c3, 12'h3a6, 12'h9e1};
	int fail_count = 0, checked = 0, cyc = 0, wcnt = 0;
	int wexp[4] = '{105, 70, 42, 30};
	logic [7:0] lvl[4] = '{8'h5a, 8'h50, 8'h46, 8'h5a};

	sbcsm_regs #(.ID_CODE(ID)) sbcsm_regs_i (.clk_in, .arst_n_in, .sck_in, .cs_n_in, .sdi_in,
		.sdo_out, .ext_readback_in, .mode_event_in, .mode_kind_in, .en_function_in,
		.bus_failure_code_in, .en_pin_out, .wd_base_tick_in, .wd_tick_out, .supply_pct_in,
		.supply_reset_out, .supply_level_pct_out, .sw_dev_mode_init_out,
		.watchdog_prescale_out, .supply_reset_level_out, .id_replaced_flag_out,
		.user_bits_b_out);
	sbcsm_mcu sbcsm_mcu_i (.clk_in, .go_in(go), .nbits_in(nb), .word_in(tx), .sdo_in(sdo_out),
		.sck_out(sck_in), .cs_n_out(cs_n_in), .sdi_out(sdi_in), .busy_out(busy),
		.done_out(done), .rx_out(rx));

	initial forever #12.5 clk_in = ~clk_in;

	always @(posedge clk_in) begin
		cyc++;
		if (wd_tick_out === 1'b1)
			wcnt++;
		if (done && nb == 5'h10) begin
			e = q.pop_front();
			`CHK(rx, e)
		end
		if (cyc == 20000) begin
			fail_count++;
			end_sim();
		end
	end

	task automatic tick(input int n);
		repeat (n) begin
			@(posedge clk_in);
			#2;
		end
	endtask

	task automatic xfer(input logic [15:0] w, input logic [15:0] x);
		if (nb == 5'h10)
			q.push_back(x);
		tx = w;
		go = 1'b1;
		tick(1);
		go = 1'b0;
		for (int i = 0; i < 200 && busy === 1'b1; i++)
			tick(1);
		tick(2);
	endtask

	task automatic pulse_mode(input sbcsm_mode_t m);
		mode_kind_in = m;
		mode_event_in = 1'b1;
		tick(1);
		mode_event_in = 1'b0;
		tick(2);
	endtask

	function automatic logic [11:0] spw(input logic s, m, input logic [1:0] p, l);
		return {2'b00, s, m, 1'b0, p, l, 3'b000};
	endfunction

	task automatic end_sim();
		$display("checks=%0d mismatches=%0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	initial begin
		tick(12);
		arst_n_in = 1'b1;
		r = 12'($urandom(28));
		xfer(16'hb000, {5'h00, ID});
		`CHK(id_replaced_flag_out, 1'b0)
		// Prescale codes rise with k, so no leftover count exceeds the new threshold.
		for (int k = 0; k < 4; k++) begin
			d = spw(k[0], k[1], k[1:0], 2'(3 - k));
			xfer({4'h6, d}, sp);
			sp = {4'h0, d};
			`CHK(sw_dev_mode_init_out, k[0])
			`CHK(supply_level_pct_out, lvl[3 - k])
			`CHK(watchdog_prescale_out, 2'(k))
			`CHK(supply_reset_level_out, 2'(3 - k))
			supply_pct_in = 8'($urandom_range(99, 60));
			tick(3);
			`CHK(supply_reset_out, supply_pct_in < lvl[3 - k])
			wcnt = 0;
			repeat (105) begin
				wd_base_tick_in = 1'b1;
				tick(1);
				wd_base_tick_in = 1'b0;
				tick(1);
			end
			tick(2);
			`CHK(wcnt, wexp[k])
			for (int c = 0; c < 16; c++) begin
				bus_failure_code_in = 4'(c);
				en_function_in = 1'($urandom);
				tick(3);
				`CHK(en_pin_out, (k[1] ? (c == 0) : en_function_in))
			end
		end
		xfer(16'h5abc, {4'h0, ext_readback_in.int_enable});
		xfer(16'h7000, sp);
		xfer(16'ha3c5, {5'h00, ID});
		xfer(16'hb000, 16'h0bc5);
		`CHK(id_replaced_flag_out, 1'b1)
		xfer({4'h9, r}, {4'h0, ext_readback_in.sys_config});
		xfer(16'hb000, 16'h0bc5);
		xfer({4'hc, r}, {4'h0, ext_readback_in.phy_control});
		`CHK(user_bits_b_out, r)
		nb = 5'h0f;
		xfer({4'he, ~r}, 16'h0000);
		nb = 5'h11;
		xfer({4'he, ~r}, 16'h0000);
		nb = 5'h10;
		xfer(16'hf000, {4'h0, r});
		xfer({4'h0, ~r}, 16'h0000);
		// A mode event of kind none must leave the special register alone.
		pulse_mode(SBCSM_MODE_NONE);
		for (int m = 2; m < 4; m++) begin
			xfer({4'h6, spw(1'b1, 1'b0, 2'h3, 2'h1)}, sp);
			sp = 16'h0000;
			pulse_mode(sbcsm_mode_t'(m));
			`CHK(user_bits_b_out, r)
			xfer(16'h7000, sp);
		end
		pulse_mode(SBCSM_MODE_POWER_ON);
		`CHK(user_bits_b_out, 12'h000)
		xfer(16'hb000, {5'h00, ID});
		end_sim();
	end
endmodule
